// file: rtl/pcs_pkg.sv
// package: constants, field layouts and carrier types of the per-port control/status bank
package pcs_pkg;
  localparam int unsigned PCS_PORTS = 4;
  localparam logic [3:0] PCS_SEL_CTRL_ONE = 4'h2;
  localparam logic [3:0] PCS_SEL_CTRL_TWO = 4'h3;
  localparam logic [3:0] PCS_SEL_STAT_ONE = 4'h4;
  localparam logic [3:0] PCS_SEL_STAT_TWO = 4'h5;
  localparam logic [3:0] PCS_SEL_DISC_LO = 4'h6;
  localparam logic [3:0] PCS_SEL_DISC_HI = 4'h7;
  localparam int unsigned PCS_BIT_PORT_OFF = 4;
  localparam int unsigned PCS_BIT_AD_START = 3;
  localparam int unsigned PCS_BIT_AD_ABORT = 2;
  localparam int unsigned PCS_BIT_DISC_FAIL = 7;
  localparam int unsigned PCS_BIT_FUNC_DONE = 6;
  localparam int unsigned PCS_BIT_WDOG = 4;
  localparam int unsigned PCS_BIT_AD_BUSY = 3;
  localparam int unsigned PCS_BIT_RES_DONE = 7;
  localparam logic [7:0] PCS_RST_BYTE = 8'h00;
  localparam logic [2:0] PCS_CLASS_MAX = 3'h4;
  localparam logic [3:0] PCS_FN_DISC1 = 4'h1;
  localparam logic [3:0] PCS_FN_DISC2 = 4'h2;
  localparam int unsigned PCS_OVERLOAD_MS = 50;

  typedef enum logic [2:0] {
    PCS_FLT_NONE = 3'b000,
    PCS_FLT_SUPPLY_WINDOW = 3'b001,
    PCS_FLT_THERMAL_SHUTDOWN = 3'b010,
    PCS_FLT_OVERLOAD = 3'b011,
    PCS_FLT_DISCONNECT = 3'b100
  } pcs_fault_t;

  typedef enum logic [2:0] {
    PCS_ST_DISABLED = 3'b000,
    PCS_ST_SEARCHING = 3'b001,
    PCS_ST_POWERING = 3'b010,
    PCS_ST_FAULT = 3'b011,
    PCS_ST_TEST = 3'b100,
    PCS_ST_OTHER_FAULT = 3'b101
  } pcs_state_t;

  // per-port status inputs from the port engine
  typedef struct packed {
    logic disc_fail;
    logic func_done;
    logic [2:0] class_code;
    logic supply_window_fault;
    logic thermal_shutdown_fault;
    logic overload_fault;
    logic load_disconnect;
    logic wdog_active;
    pcs_state_t state;
    logic ad_done;
    logic [14:0] ad_result;
  } pcs_port_in_t;

  // per-port controls to the port engine
  typedef struct packed {
    logic port_off;
    logic ad_start;
    logic ad_abort;
    logic [3:0] func_sel;
    logic func_write;
    logic ad_busy;
  } pcs_port_out_t;
endpackage : pcs_pkg

// file: rtl/pcs_port_regs.sv
// file: per-port control and status register bank behind the management port
`timescale 1ns/1ns
module pcs_port_regs #(
  parameter int unsigned PORTS = pcs_pkg::PCS_PORTS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [$clog2(PORTS)-1:0] reg_port,
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire pcs_pkg::pcs_port_in_t [PORTS-1:0] port_in,
  output pcs_pkg::pcs_port_out_t [PORTS-1:0] port_out
);
  import pcs_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [PORTS-1:0] port_off_r;
  logic [PORTS-1:0] ad_start_r;
  logic [PORTS-1:0] ad_abort_r;
  logic [PORTS-1:0] ad_busy_r;
  logic [PORTS-1:0] func_done_r;
  logic [PORTS-1:0] res_done_r;
  logic [PORTS-1:0] fn_wr_r;
  logic [3:0] func_sel_r [PORTS];
  logic [14:0] result_r [PORTS];
  logic [7:0] stat_one [PORTS];
  logic [7:0] stat_two [PORTS];

  function automatic logic hit(input logic [$clog2(PORTS)-1:0] p, input int unsigned i,
                               input logic [3:0] s, input logic [3:0] want);
    hit = (p == i[$clog2(PORTS)-1:0]) && (s == want);
  endfunction : hit

  // fault priority encoder; codes 101..111 cannot appear
  function automatic logic [2:0] fault_code(input pcs_port_in_t pi);
    if (pi.supply_window_fault) fault_code = PCS_FLT_SUPPLY_WINDOW;
    else if (pi.thermal_shutdown_fault) fault_code = PCS_FLT_THERMAL_SHUTDOWN;
    else if (pi.overload_fault) fault_code = PCS_FLT_OVERLOAD;
    else if (pi.load_disconnect) fault_code = PCS_FLT_DISCONNECT;
    else fault_code = PCS_FLT_NONE;
  endfunction : fault_code

  // ****************************************
  // control two and the control-one write strobe, per port
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_off_r <= '0;
      ad_start_r <= '0;
      ad_abort_r <= '0;
      fn_wr_r <= '0;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        fn_wr_r[i] <= reg_wr && hit(reg_port, i, reg_sel, PCS_SEL_CTRL_ONE);
        ad_start_r[i] <= 1'b0;
        if (reg_wr && hit(reg_port, i, reg_sel, PCS_SEL_CTRL_TWO)) begin
          port_off_r[i] <= reg_wdata[PCS_BIT_PORT_OFF];
          ad_start_r[i] <= reg_wdata[PCS_BIT_AD_START];
          ad_abort_r[i] <= reg_wdata[PCS_BIT_AD_ABORT];
        end
      end
    end
  end

  // ****************************************
  // function select shadow
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < PORTS; i++) func_sel_r[i] <= '0;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        if (reg_wr && hit(reg_port, i, reg_sel, PCS_SEL_CTRL_ONE)) begin
          func_sel_r[i] <= reg_wdata[3:0];
        end
      end
    end
  end

  // ****************************************
  // conversion tracking and result capture
  // ****************************************
  // an abort wins over a finishing conversion so no partial result lands
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ad_busy_r <= '0;
      res_done_r <= '0;
      for (int i = 0; i < PORTS; i++) result_r[i] <= '0;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        if (ad_abort_r[i]) begin
          ad_busy_r[i] <= 1'b0;
        end else if (ad_start_r[i]) begin
          ad_busy_r[i] <= 1'b1;
        end else if (ad_busy_r[i] && port_in[i].ad_done) begin
          ad_busy_r[i] <= 1'b0;
          result_r[i] <= port_in[i].ad_result;
        end
        if (fn_wr_r[i] && (func_sel_r[i] == PCS_FN_DISC1 || func_sel_r[i] == PCS_FN_DISC2)) begin
          res_done_r[i] <= 1'b0;
        end else if (ad_busy_r[i] && port_in[i].ad_done && !ad_abort_r[i]) begin
          res_done_r[i] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // function-done flag
  // ****************************************
  // done from the engine wins over the clearing write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      func_done_r <= '0;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        if (port_in[i].func_done) func_done_r[i] <= 1'b1;
        else if (fn_wr_r[i]) func_done_r[i] <= 1'b0;
      end
    end
  end

  // ****************************************
  // status assembly
  // ****************************************
  always_comb begin
    for (int i = 0; i < PORTS; i++) begin
      stat_one[i] = PCS_RST_BYTE;
      stat_one[i][PCS_BIT_DISC_FAIL] = port_in[i].disc_fail;
      stat_one[i][PCS_BIT_FUNC_DONE] = func_done_r[i];
      // out-of-range class codes clamp to the top class
      stat_one[i][5:3] = (port_in[i].class_code > PCS_CLASS_MAX) ? PCS_CLASS_MAX
                                                                 : port_in[i].class_code;
      stat_one[i][2:0] = fault_code(port_in[i]);
      stat_two[i] = PCS_RST_BYTE;
      stat_two[i][PCS_BIT_WDOG] = port_in[i].wdog_active;
      stat_two[i][PCS_BIT_AD_BUSY] = ad_busy_r[i];
      // undefined state codes report as other fault
      stat_two[i][2:0] = (port_in[i].state > PCS_ST_OTHER_FAULT) ? PCS_ST_OTHER_FAULT
                                                                  : port_in[i].state;
      port_out[i].port_off = port_off_r[i];
      port_out[i].ad_start = ad_start_r[i];
      port_out[i].ad_abort = ad_abort_r[i];
      port_out[i].func_sel = func_sel_r[i];
      port_out[i].func_write = fn_wr_r[i];
      port_out[i].ad_busy = ad_busy_r[i];
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // status is registered at read time; writes to read-only selects fall through
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= PCS_RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_sel)
        PCS_SEL_CTRL_ONE: reg_rdata <= {4'h0, func_sel_r[reg_port]};
        PCS_SEL_CTRL_TWO: reg_rdata <= {3'h0, port_off_r[reg_port], ad_start_r[reg_port],
                                        ad_abort_r[reg_port], 2'h0};
        PCS_SEL_STAT_ONE: reg_rdata <= stat_one[reg_port];
        PCS_SEL_STAT_TWO: reg_rdata <= stat_two[reg_port];
        PCS_SEL_DISC_LO: reg_rdata <= result_r[reg_port][7:0];
        PCS_SEL_DISC_HI: reg_rdata <= {res_done_r[reg_port], result_r[reg_port][14:8]};
        default: reg_rdata <= PCS_RST_BYTE;
      endcase
    end
  end
endmodule : pcs_port_regs

// file: verif/pcs_port_regs_assertions.sv
// checker: timing relations of the port bank seen at its ports
`timescale 1ns/1ns
module pcs_port_regs_chk #(
  parameter int unsigned PORTS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [$clog2(PORTS)-1:0] reg_port,
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire pcs_pkg::pcs_port_in_t [PORTS-1:0] port_in,
  input wire pcs_pkg::pcs_port_out_t [PORTS-1:0] port_out
);
  import pcs_pkg::*;
  // ***
  // port zero relations, plus unmapped reads on any port
  // ***
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic w3;
  assign w3 = reg_wr && reg_sel == 4'h3 && reg_port == 0;
  a_start_pulse: assert property (w3 && reg_wdata[3:2] == 2'h2 && !port_out[0].ad_abort
    |=> port_out[0].ad_start) else $error("no start pulse");
  a_start_clear: assert property (port_out[0].ad_start && !w3 |=> !port_out[0].ad_start)
    else $error("start not self clearing");
  a_port_off: assert property (w3 |=> port_out[0].port_off == $past(reg_wdata[4]))
    else $error("port off wrong");
  a_abort_level: assert property (w3 |=> port_out[0].ad_abort == $past(reg_wdata[2]))
    else $error("abort level wrong");
  a_busy_start: assert property (port_out[0].ad_start && !port_out[0].ad_abort
    |=> port_out[0].ad_busy) else $error("busy not set");
  a_abort_busy: assert property (port_out[0].ad_abort |=> !port_out[0].ad_busy)
    else $error("busy kept on abort");
  a_func_write: assert property (reg_wr && reg_sel == 4'h2 && reg_port == 0 |=>
    port_out[0].func_write && port_out[0].func_sel == $past(reg_wdata[3:0]))
    else $error("function write lost");
  a_unmapped_rd: assert property (reg_rd && (reg_sel < 4'h2 || reg_sel > 4'h7)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_stat_two: assert property (reg_rd && reg_sel == 4'h5 && reg_port == 0 |=>
    reg_rdata[7:3] == {3'h0, $past(port_in[0].wdog_active), $past(port_out[0].ad_busy)})
    else $error("status two wrong");
  c_start: cover property (port_out[0].ad_start);
  c_abort: cover property (port_out[0].ad_abort && port_out[0].ad_busy);
  c_func: cover property (port_out[0].func_write);
endmodule : pcs_port_regs_chk

// file: verif/pcs_engine_model.sv
// partner: behavioural port engine behind the bank
`timescale 1ns/1ns
module pcs_engine_model #(
  parameter int unsigned PORTS = 4,
  parameter int unsigned AD_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire pcs_pkg::pcs_port_in_t [PORTS-1:0] cfg,
  input wire logic [14:0] res,
  input wire pcs_pkg::pcs_port_out_t [PORTS-1:0] port_out,
  output pcs_pkg::pcs_port_in_t [PORTS-1:0] port_in
);
  import pcs_pkg::*;
  // ***
  // conversion timing
  // ***
  int cnt [PORTS];
  logic [PORTS-1:0] done_p;
  logic [PORTS-1:0] fdone_p;
  always_comb begin
    port_in = cfg;
    for (int i = 0; i < PORTS; i++) begin
      port_in[i].ad_done = done_p[i];
      port_in[i].func_done = fdone_p[i];
      // result only valid with the done pulse, garbage otherwise
      port_in[i].ad_result = done_p[i] ? res : ~res;
    end
  end
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_p <= '0;
      fdone_p <= '0;
      cnt <= '{default: 0};
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        done_p[i] <= cnt[i] == 1;
        fdone_p[i] <= port_out[i].func_write && port_out[i].func_sel != 4'h0;
        if (port_out[i].ad_abort) cnt[i] <= 0;
        else if (port_out[i].ad_start) cnt[i] <= AD_CYC;
        else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
      end
    end
  end
endmodule : pcs_engine_model

// file: verif/pcs_port_regs_tb.sv
// testbench: random and directed checks of the port bank
`timescale 1ns/1ns
module pcs_port_regs_tb;
  import pcs_pkg::*;
  logic sys_clk, rst_b, reg_wr, reg_rd;
  logic [1:0] reg_port, p;
  logic [3:0] reg_sel;
  logic [7:0] reg_wdata, reg_rdata, old;
  logic [14:0] res;
  pcs_port_in_t [3:0] cfg, port_in;
  pcs_port_out_t [3:0] port_out;
  int err_count = 0;
  int cmp_count = 0;
  pcs_port_regs #(.PORTS(4)) pcs_port_regs_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_port(reg_port), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_in(port_in), .port_out(port_out));
  pcs_engine_model #(.PORTS(4)) pcs_engine_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .cfg(cfg), .res(res), .port_out(port_out), .port_in(port_in));
  // ***
  // tasks
  // ***
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic wr(input logic [1:0] q, input logic [3:0] s, input logic [7:0] d);
    {reg_port, reg_sel, reg_wdata, reg_wr} = {q, s, d, 1'h1};
    @(negedge sys_clk);
    reg_wr = 1'h0;
    @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [1:0] q, input logic [3:0] s, input logic [7:0] exp);
    {reg_port, reg_sel, reg_rd} = {q, s, 1'h1};
    @(negedge sys_clk);
    reg_rd = 1'h0;
    @(negedge sys_clk);
    cmp8(reg_rdata, exp);
  endtask : rd
  function automatic logic [7:0] stat1(input pcs_port_in_t c, input logic dn);
    logic [2:0] f;
    f = c.supply_window_fault ? 3'h1 : c.thermal_shutdown_fault ? 3'h2 :
      c.overload_fault ? 3'h3 : c.load_disconnect ? 3'h4 : 3'h0;
    return {c.disc_fail, dn, (c.class_code > 3'h4) ? 3'h4 : c.class_code, f};
  endfunction : stat1
  function automatic logic [7:0] stat2(input pcs_port_in_t c, input logic bz);
    return {3'h0, c.wdog_active, bz, (c.state > 3'h5) ? 3'h5 : 3'(c.state)};
  endfunction : stat2
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // ***
  // sequence
  // ***
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  initial begin
    {reg_wr, reg_rd, reg_port, reg_sel, reg_wdata, res, cfg, rst_b} = '0;
    void'($urandom(32'hB202D388));
    repeat (5) @(negedge sys_clk);
    rst_b = 1'h1;
    for (int s = 0; s < 16; s++) rd(2'h0, 4'(s), 8'h00);
    $display("reset test done");
    for (int i = 0; i < 40; i++) begin
      p = 2'($urandom);
      for (int k = 0; k < 4; k++) cfg[k] = 29'($urandom);
      wr(p, 4'h4 + 4'($urandom_range(3)), 8'($urandom));
      rd(p, 4'h4, stat1(cfg[p], 1'h0));
      rd(p, 4'h5, stat2(cfg[p], 1'h0));
    end
    $display("random status test done");
    cfg = '0;
    wr(2'h0, 4'h2, 8'h01);
    repeat (3) @(negedge sys_clk);
    rd(2'h0, 4'h4, 8'h40);
    res = 15'($urandom);
    wr(2'h0, 4'h3, 8'h08);
    @(negedge sys_clk);
    rd(2'h0, 4'h5, 8'h08);
    repeat (12) @(negedge sys_clk);
    rd(2'h0, 4'h5, 8'h00);
    rd(2'h0, 4'h6, res[7:0]);
    rd(2'h0, 4'h7, {1'h1, res[14:8]});
    wr(2'h0, 4'h2, 8'h00);
    rd(2'h0, 4'h4, 8'h00);
    $display("conversion test done");
    old = res[7:0];
    res = ~res;
    wr(2'h0, 4'h3, 8'h08);
    wr(2'h0, 4'h3, 8'h04);
    repeat (12) @(negedge sys_clk);
    rd(2'h0, 4'h5, 8'h00);
    rd(2'h0, 4'h6, old);
    rd(2'h0, 4'h3, 8'h04);
    wr(2'h0, 4'h2, 8'h02);
    rd(2'h0, 4'h7, {1'h0, ~res[14:8]});
    wr(2'h0, 4'h3, 8'h10);
    cmp8({7'h0, port_out[0].port_off}, 8'h01);
    $display("abort and port off test done");
    rst_b = 1'h0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'h1;
    rd(2'h0, 4'h3, 8'h00);
    rd(2'h0, 4'h7, 8'h00);
    rd(2'h0, 4'h4, 8'h00);
    $display("mid-run reset test done");
    summarize();
  end
endmodule : pcs_port_regs_tb
bind pcs_port_regs pcs_port_regs_chk #(.PORTS(PORTS)) pcs_port_regs_chk_inst (.sys_clk(sys_clk),
  .rst_b(rst_b), .reg_port(reg_port), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_in(port_in), .port_out(port_out));
